// [rtl/standby_fault_sequencer_pkg.sv]
// package: constants, states and carrier structs for the standby/fault sequencer
package standby_fault_sequencer_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;
  // timer durations in ms, figures as defaults of our own
  localparam int unsigned RESTART_FORCE_MS = 100;
  localparam int unsigned FAULT_RETRY_MS = 1000;
  localparam int unsigned RESTART_FORCE_CYC = RESTART_FORCE_MS * (CLK_HZ / 1000);
  localparam int unsigned FAULT_RETRY_CYC = FAULT_RETRY_MS * (CLK_HZ / 1000);
  localparam int unsigned TIMER_W = 32;

  // apb map
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] FORCE_LEN_ADDR = 8'h08;
  localparam logic [7:0] RETRY_LEN_ADDR = 8'h0C;
  // ctrl field positions
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_LOWTRUE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;

  typedef enum logic [2:0] {
    ST_CHARGE = 3'b000,
    ST_RUN = 3'b001,
    ST_STANDBY = 3'b010,
    ST_RETRY = 3'b011,
    ST_LATCHED = 3'b100,
    ST_DRAIN = 3'b101,
    ST_HOT = 3'b110
  } seq_state_t;

  typedef struct packed {
    logic aboveStart;   // supply at or above start level
    logic belowUv;      // supply below undervoltage level
    logic belowFour;    // supply forced below 4 V
    logic drained;      // supply fully discharged
    logic remoteAbove;  // remote_sense above standby_entry_threshold
    logic remoteBelowExit; // remote_sense below standby_exit_threshold
    logic thermalTrip;  // over-temperature, with hysteresis
    logic lineSag;      // line_sag event confirmed
    logic lineCapDischarge; // line_cap_discharge confirmed
    logic slaveReady;   // slave supply-ready
    logic slaveShutdown; // slave shutdown request
  } sense_t;

  typedef struct packed {
    logic startSource;  // startup current source on
    logic holdRegulate; // regulate supply at the 5 V hold level
    logic drainSwitch;  // discharge switch on
    logic inhibit;      // slave inhibit, pulls feedback_node low
    logic remotePullDown; // pulls remote_sense low
    logic lowPower;     // minimum consumption
  } drive_t;

endpackage

// [rtl/standby_fault_sequencer.sv]
// standby, fault retry, latch-off and thermal sequencing with apb registers
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps

// Function
// - enter standby on remote above entry level, or below in low-true
// - leave standby when remote crosses back over exit threshold (low-true leaves on remote above entry level)
// - high-true: pull remote low while restart force timer runs
// - start force timer after plug-in, fault, supply loss, sag, thermal
// - no force timer or pull-down when restarting from standby
// - low-true: standby when remote low and supply drops below undervoltage
// - low-true: ignore remote for standby entry while we hold slave feedback low
// - inhibit slave in standby, faults, latch, discharge, sag, startup
// - undervoltage starts retry timer, discharge supply to hold level
// - regulate supply at 5 V hold level while retry timer runs
// - fully discharge supply before any fault restart
// - fault restart on retry expiry or supply forced below 4 V
// - slave ready stops startup current source early
// - slave ready honoured only while charging during startup
// - slave stopping silently looks like supply loss, auto-recovery
// - latch-off on rising edge of slave shutdown only
// - latch-off held until line discharge or supply below 4 V
// - slave shutdown honoured only during regular operation
// - thermal trip in stable run inhibits slave at once
// - after thermal trip clears, fully discharge supply to restart
// - standby inhibits slave, discharges supply, minimum consumption
// - thermal trip outside run only pauses the current sequence
module standby_fault_sequencer (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire standby_fault_sequencer_pkg::sense_t sense,
  output standby_fault_sequencer_pkg::drive_t drive,
  output logic [2:0] seqState,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  //////////////////////////////////////////////////////////////////////////
  // register bus

  logic [1:0] ctrl_q;
  logic [31:0] forceLen_q;
  logic [31:0] retryLen_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [7:0] eventCnt_q;

  wire apbAccess = psel && penable;
  wire apbWrite = apbAccess && pwrite;
  wire hitCtrl = (paddr == standby_fault_sequencer_pkg::CTRL_ADDR);
  wire hitStatus = (paddr == standby_fault_sequencer_pkg::STATUS_ADDR);
  wire hitForce = (paddr == standby_fault_sequencer_pkg::FORCE_LEN_ADDR);
  wire hitRetry = (paddr == standby_fault_sequencer_pkg::RETRY_LEN_ADDR);
  wire hitAny = hitCtrl || hitStatus || hitForce || hitRetry;
  wire enable = ctrl_q[standby_fault_sequencer_pkg::CTRL_ENABLE_BIT];
  wire lowTrue = ctrl_q[standby_fault_sequencer_pkg::CTRL_LOWTRUE_BIT];

  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  //////////////////////////////////////////////////////////////////////////
  // sequencer

  standby_fault_sequencer_pkg::seq_state_t state_q, state_d;
  logic [31:0] forceCnt_q;
  logic [31:0] retryCnt_q;
  logic forceArm_q;   // restart force latch
  logic charged_q;    // startup finished (start level reached or slave ready)
  logic shutdownPrev_q;
  logic hotPaused_q;

  wire inRun = (state_q == standby_fault_sequencer_pkg::ST_RUN);
  wire retryDone = (retryCnt_q == 32'h0);
  wire forceRun = (forceCnt_q != 32'h0);
  wire shutdownRise = sense.slaveShutdown && !shutdownPrev_q;
  wire stable = inRun && charged_q && !sense.belowUv;
  // we hold feedback low whenever the slave is inhibited
  wire holdingFb = drive.inhibit;
  // high-true: above entry; low-true: remote below entry while we do not
  // drive the feedback node, and only once the supply collapses
  wire standbyHigh = !lowTrue && sense.remoteAbove && !forceRun;
  wire standbyLow = lowTrue && !sense.remoteAbove && !holdingFb
    && sense.belowUv;
  wire standbyReq = standbyHigh || standbyLow;
  // high-true exit on drop below exit level; low-true exit when remote rises
  wire exitReq = lowTrue ? sense.remoteAbove : sense.remoteBelowExit;
  wire startDone = sense.aboveStart || sense.slaveReady;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      standby_fault_sequencer_pkg::ST_CHARGE: begin
        if (sense.lineCapDischarge) begin
          state_d = standby_fault_sequencer_pkg::ST_DRAIN;
        end else if (startDone) begin
          state_d = standby_fault_sequencer_pkg::ST_RUN;
        end
      end
      standby_fault_sequencer_pkg::ST_RUN: begin
        if (sense.lineCapDischarge || sense.lineSag) begin
          state_d = standby_fault_sequencer_pkg::ST_DRAIN;
        end else if (sense.thermalTrip && stable) begin
          state_d = standby_fault_sequencer_pkg::ST_HOT;
        end else if (shutdownRise && !sense.belowUv) begin
          state_d = standby_fault_sequencer_pkg::ST_LATCHED;
        end else if (standbyReq) begin
          state_d = standby_fault_sequencer_pkg::ST_STANDBY;
        end else if (sense.belowUv) begin
          state_d = standby_fault_sequencer_pkg::ST_RETRY;
        end
      end
      standby_fault_sequencer_pkg::ST_STANDBY: begin
        if (exitReq || sense.lineCapDischarge) begin
          state_d = standby_fault_sequencer_pkg::ST_DRAIN;
        end
      end
      standby_fault_sequencer_pkg::ST_RETRY: begin
        if (retryDone || sense.belowFour) begin
          state_d = standby_fault_sequencer_pkg::ST_DRAIN;
        end
      end
      standby_fault_sequencer_pkg::ST_LATCHED: begin
        if (sense.lineCapDischarge || sense.belowFour) begin
          state_d = standby_fault_sequencer_pkg::ST_DRAIN;
        end
      end
      standby_fault_sequencer_pkg::ST_DRAIN: begin
        if (sense.drained && !sense.lineCapDischarge) begin
          state_d = standby_fault_sequencer_pkg::ST_CHARGE;
        end
      end
      standby_fault_sequencer_pkg::ST_HOT: begin
        if (!sense.thermalTrip) begin
          state_d = standby_fault_sequencer_pkg::ST_DRAIN;
        end
      end
      default: state_d = standby_fault_sequencer_pkg::ST_DRAIN;
    endcase
  end

  // thermal trip outside run, other than in the hot state, freezes the sequence in place
  wire pause = sense.thermalTrip && !inRun
    && (state_q != standby_fault_sequencer_pkg::ST_HOT);
  wire advance = clkEn && enable && !pause;
  wire enterCharge = (state_d == standby_fault_sequencer_pkg::ST_CHARGE)
    && (state_q == standby_fault_sequencer_pkg::ST_DRAIN);
  wire leaveCharge = (state_q == standby_fault_sequencer_pkg::ST_CHARGE)
    && (state_d == standby_fault_sequencer_pkg::ST_RUN);
  // causes that arm the force timer for the next startup
  wire armEvent = sense.lineCapDischarge || sense.lineSag
    || (state_q == standby_fault_sequencer_pkg::ST_RETRY)
    || (state_q == standby_fault_sequencer_pkg::ST_HOT)
    || (inRun && sense.belowUv && !sense.remoteAbove);
  // leaving standby clears the latch unless a line cap discharge or line sag arms it, so refill bursts stay short
  wire disarm = (state_q == standby_fault_sequencer_pkg::ST_STANDBY)
    && (state_d != standby_fault_sequencer_pkg::ST_STANDBY);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= standby_fault_sequencer_pkg::ST_DRAIN;
      forceCnt_q <= 32'h0;
      retryCnt_q <= 32'h0;
      forceArm_q <= 1'b1;
      charged_q <= 1'b0;
      shutdownPrev_q <= 1'b0;
    end else if (advance) begin
      state_q <= state_d;
      shutdownPrev_q <= sense.slaveShutdown;
      if (armEvent) begin
        forceArm_q <= 1'b1;
      end else if (disarm) begin
        forceArm_q <= 1'b0;
      end
      if (leaveCharge && forceArm_q && !disarm) begin
        forceCnt_q <= forceLen_q;
        forceArm_q <= armEvent;
      end else if (forceCnt_q != 32'h0) begin
        forceCnt_q <= forceCnt_q - 32'h1;
      end
      if (inRun && state_d == standby_fault_sequencer_pkg::ST_RETRY) begin
        retryCnt_q <= retryLen_q;
      end else if (retryCnt_q != 32'h0) begin
        retryCnt_q <= retryCnt_q - 32'h1;
      end
      if (enterCharge) begin
        charged_q <= 1'b0;
      end else if (leaveCharge) begin
        charged_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hotPaused_q <= 1'b0;
    end else if (clkEn) begin
      hotPaused_q <= pause;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // switch drives

  wire inCharge = (state_q == standby_fault_sequencer_pkg::ST_CHARGE);
  wire inRetry = (state_q == standby_fault_sequencer_pkg::ST_RETRY);
  wire inStandby = (state_q == standby_fault_sequencer_pkg::ST_STANDBY);
  assign drive.startSource = inCharge && !startDone && !pause;
  assign drive.holdRegulate = inRetry;
  assign drive.drainSwitch = (state_q == standby_fault_sequencer_pkg::ST_DRAIN)
    || inStandby || (inRetry && !sense.belowFour);
  assign drive.inhibit = !inRun || standbyHigh;
  assign drive.remotePullDown = !lowTrue && forceRun && inRun;
  assign drive.lowPower = inStandby;
  assign seqState = state_q;

  //////////////////////////////////////////////////////////////////////////
  // register processes

  logic [31:0] statusWord;
  always_comb begin
    statusWord = {8'h0, eventCnt_q, 8'h0, hotPaused_q, forceRun,
      forceArm_q, charged_q, 1'b0, state_q};
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_q <= standby_fault_sequencer_pkg::CTRL_RESET;
      forceLen_q <= standby_fault_sequencer_pkg::RESTART_FORCE_CYC;
      retryLen_q <= standby_fault_sequencer_pkg::FAULT_RETRY_CYC;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
      eventCnt_q <= 8'h0;
    end else if (clkEn) begin
      pslverr_q <= psel && !penable && !hitAny;
      if (psel && !penable && !pwrite) begin
        prdata_q <= hitCtrl ? {30'h0, ctrl_q} :
          hitStatus ? statusWord :
          hitForce ? forceLen_q :
          hitRetry ? retryLen_q : 32'h0;
      end
      if (apbWrite && hitCtrl) begin
        ctrl_q <= pwdata[1:0];
      end
      if (apbWrite && hitForce) begin
        forceLen_q <= pwdata;
      end
      if (apbWrite && hitRetry) begin
        retryLen_q <= pwdata;
      end
      if (advance && state_q != state_d) begin
        eventCnt_q <= eventCnt_q + 8'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  AST_INHIBIT_OFF_RUN: assert property (@(posedge ref_clk) disable iff (reset)
    !inRun |-> drive.inhibit)
    else $error("inhibit low outside run");
  AST_HOT_INHIBIT: assert property (@(posedge ref_clk) disable iff (reset)
    (advance && stable && sense.thermalTrip && !sense.lineSag
     && !sense.lineCapDischarge) |=> drive.inhibit)
    else $error("thermal trip did not inhibit");
  AST_HOT_DRAIN: assert property (@(posedge ref_clk) disable iff (reset)
    (state_q == standby_fault_sequencer_pkg::ST_HOT && advance
     && !sense.thermalTrip) |=> drive.drainSwitch)
    else $error("no discharge after thermal clear");
  AST_RETRY_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
    inRetry |-> drive.holdRegulate && drive.inhibit)
    else $error("retry without hold");
  AST_LATCH_STAYS: assert property (@(posedge ref_clk) disable iff (reset)
    (state_q == standby_fault_sequencer_pkg::ST_LATCHED
     && !sense.lineCapDischarge && !sense.belowFour)
    |=> state_q == standby_fault_sequencer_pkg::ST_LATCHED)
    else $error("latch-off released early");
  AST_PULLDOWN_HIGHTRUE: assert property (@(posedge ref_clk)
    disable iff (reset) drive.remotePullDown |-> !lowTrue && forceCnt_q != 0)
    else $error("pull-down without timer");
  AST_STANDBY_LOWPWR: assert property (@(posedge ref_clk)
    disable iff (reset) inStandby |-> drive.lowPower && drive.drainSwitch)
    else $error("standby not low power");
  AST_PAUSE_FREEZE: assert property (@(posedge ref_clk)
    disable iff (reset) (pause && clkEn) |=> $stable(state_q))
    else $error("pause moved the sequence");
  AST_SOURCE_STOP: assert property (@(posedge ref_clk)
    disable iff (reset) (inCharge && sense.slaveReady) |-> !drive.startSource)
    else $error("source on with slave ready");

  //////////////////////////////////////////////////////////////////////////
  // transition checks; each names the edge it guards so a broken decode
  // shows up at the cycle it happens, not at the far end of a sequence
  AST_HIGH_ENTRY: assert property (@(posedge ref_clk)
    disable iff (reset) (inRun && advance && !lowTrue && sense.remoteAbove
     && !forceRun && !sense.lineSag && !sense.lineCapDischarge
     && !(sense.thermalTrip && stable) && !(shutdownRise && !sense.belowUv))
    |=> inStandby)
    else $error("high-true standby not entered");
  AST_LOW_ENTRY: assert property (@(posedge ref_clk)
    disable iff (reset) (inRun && advance && lowTrue && !sense.remoteAbove
     && sense.belowUv && !sense.lineSag && !sense.lineCapDischarge)
    |=> inStandby)
    else $error("low-true standby not entered");
  AST_LOW_IGNORE: assert property (@(posedge ref_clk)
    disable iff (reset) (lowTrue && drive.inhibit && !inStandby)
    |=> !inStandby)
    else $error("remote acted on while feedback held");
  AST_STANDBY_EXIT: assert property (@(posedge ref_clk)
    disable iff (reset) (inStandby && advance && exitReq)
    |=> state_q == standby_fault_sequencer_pkg::ST_DRAIN)
    else $error("standby not left on exit level");
  AST_FORCE_LOAD: assert property (@(posedge ref_clk)
    disable iff (reset) (advance && leaveCharge && forceArm_q)
    |=> forceCnt_q == $past(forceLen_q))
    else $error("force timer not started on armed start");
  AST_STANDBY_DISARM: assert property (@(posedge ref_clk)
    disable iff (reset) (advance && inStandby && !armEvent
     && state_d != standby_fault_sequencer_pkg::ST_STANDBY) |=> !forceArm_q)
    else $error("force latch kept after standby");
  AST_RETRY_LOAD: assert property (@(posedge ref_clk)
    disable iff (reset) (advance && inRun
     && state_d == standby_fault_sequencer_pkg::ST_RETRY)
    |=> inRetry && retryCnt_q == $past(retryLen_q) && drive.inhibit)
    else $error("retry timer not started");
  AST_RETRY_EXIT: assert property (@(posedge ref_clk)
    disable iff (reset) (advance && inRetry && (retryDone || sense.belowFour))
    |=> state_q == standby_fault_sequencer_pkg::ST_DRAIN)
    else $error("retry not ended");
  AST_CHARGE_FROM_DRAIN: assert property (@(posedge ref_clk)
    disable iff (reset) $rose(inCharge)
    |-> $past(sense.drained)
     && $past(state_q) == standby_fault_sequencer_pkg::ST_DRAIN)
    else $error("charge began without full discharge");
  AST_LATCH_ENTRY: assert property (@(posedge ref_clk)
    disable iff (reset) (inRun && advance && shutdownRise && !sense.belowUv
     && !sense.lineSag && !sense.lineCapDischarge && !sense.thermalTrip)
    |=> state_q == standby_fault_sequencer_pkg::ST_LATCHED)
    else $error("shutdown edge did not latch");
  AST_LATCH_ONLY_RUN: assert property (@(posedge ref_clk)
    disable iff (reset) (!inRun
     && state_q != standby_fault_sequencer_pkg::ST_LATCHED)
    |=> state_q != standby_fault_sequencer_pkg::ST_LATCHED)
    else $error("latch-off outside regular operation");
  AST_RUN_ENTRY: assert property (@(posedge ref_clk)
    disable iff (reset) (inCharge && advance && !sense.lineCapDischarge
     && (sense.aboveStart || sense.slaveReady)) |=> inRun)
    else $error("startup not ended");
  AST_SOURCE_CHARGE: assert property (@(posedge ref_clk)
    disable iff (reset) drive.startSource |-> inCharge && !sense.slaveReady)
    else $error("source on outside startup");
  AST_SAG_DRAIN: assert property (@(posedge ref_clk)
    disable iff (reset) (inRun && advance
     && (sense.lineSag || sense.lineCapDischarge))
    |=> drive.inhibit && drive.drainSwitch)
    else $error("sag or unplug did not stop the slave");
  AST_HOT_HOLD: assert property (@(posedge ref_clk)
    disable iff (reset) (state_q == standby_fault_sequencer_pkg::ST_HOT
     && sense.thermalTrip) |=> state_q == standby_fault_sequencer_pkg::ST_HOT)
    else $error("thermal hold released while hot");
  AST_PAUSE_SOURCE: assert property (@(posedge ref_clk)
    disable iff (reset) pause |-> !drive.startSource && !advance)
    else $error("paused sequence still charging");
  AST_SUPPLY_LOSS: assert property (@(posedge ref_clk)
    disable iff (reset) (inRun && advance && sense.belowUv && !lowTrue
     && !sense.remoteAbove && !sense.lineSag && !sense.lineCapDischarge)
    |=> inRetry)
    else $error("supply loss did not start auto-recovery");
  AST_CLKEN_FREEZE: assert property (@(posedge ref_clk)
    disable iff (reset) !clkEn |=> $stable(state_q) && $stable(forceCnt_q)
     && $stable(retryCnt_q) && $stable(forceArm_q))
    else $error("state moved with clock enable low");

endmodule

// [bench/slave_side_model.sv]
// slave controller and opto-coupler model on the far side of the sequencer
`timescale 1ns/1ps

module slave_side_model #(
  parameter int READY_DLY = 3
) (
  input wire logic ref_clk,
  input wire standby_fault_sequencer_pkg::sense_t want,
  input wire standby_fault_sequencer_pkg::drive_t drive,
  output standby_fault_sequencer_pkg::sense_t sense
);
  logic [7:0] chargeCnt_q;

  // slave only reports ready once its supply had time to charge
  always_ff @(posedge ref_clk) begin
    if (!drive.startSource) begin
      chargeCnt_q <= 8'h00;
    end else if (chargeCnt_q != 8'hFF) begin
      chargeCnt_q <= chargeCnt_q + 8'h01;
    end
  end

  always_comb begin
    sense = want;
    // the internal pull-down beats a stale remote bias
    sense.remoteAbove = want.remoteAbove & ~drive.remotePullDown;
    sense.slaveReady = want.slaveReady & (chargeCnt_q >= READY_DLY);
  end
endmodule

// [bench/standby_fault_sequencer_tb_top.sv]
// self-checking bench for the standby/fault sequencer
`timescale 1ns/1ps

`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin \
  err_total++; $display("wrong value %s exp %0h got %0h", nm, ex, gt); \
  end end

module standby_fault_sequencer_tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic clkEn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] seqState;
  standby_fault_sequencer_pkg::sense_t env = '0;
  standby_fault_sequencer_pkg::sense_t sense;
  standby_fault_sequencer_pkg::drive_t drive;
  int err_total = 0;
  int compares = 0;
  logic [31:0] rd;
  logic er;

  always #12.5 ref_clk = ~ref_clk;

  slave_side_model #(.READY_DLY(3)) partner (.ref_clk(ref_clk),
    .want(env), .drive(drive), .sense(sense));

  standby_fault_sequencer dut (.ref_clk(ref_clk), .reset(reset),
    .clkEn(clkEn), .sense(sense), .drive(drive), .seqState(seqState),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    // wait states are allowed; the watchdog ends a hang
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_state(input logic [2:0] st, input int lim);
    int n;
    n = 0;
    while (seqState !== st && n < lim) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    `CHK("seqState", st, seqState)
  endtask

  task automatic start_up();
    @(posedge ref_clk);
    env.drained <= 1'b1;
    wait_state(standby_fault_sequencer_pkg::ST_CHARGE, 10);
    `CHK("inhibit", 1'b1, drive.inhibit)
    `CHK("startSource", 1'b1, drive.startSource)
    env.drained <= 1'b0;
    env.aboveStart <= 1'b1;
    wait_state(standby_fault_sequencer_pkg::ST_RUN, 10);
    `CHK("inhibitRun", 1'b0, drive.inhibit)
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    `CHK("resetState", standby_fault_sequencer_pkg::ST_DRAIN, seqState)
    apb(1'b0, standby_fault_sequencer_pkg::CTRL_ADDR, 32'h0);
    `CHK("ctrl", 32'h00000001, rd)
    apb(1'b0, standby_fault_sequencer_pkg::STATUS_ADDR, 32'h0);
    `CHK("status", standby_fault_sequencer_pkg::ST_DRAIN, rd[2:0])
    apb(1'b1, standby_fault_sequencer_pkg::FORCE_LEN_ADDR, 32'h00000014);
    apb(1'b1, standby_fault_sequencer_pkg::RETRY_LEN_ADDR, 32'h00000014);
    apb(1'b0, standby_fault_sequencer_pkg::RETRY_LEN_ADDR, 32'h0);
    `CHK("retryLen", 32'h00000014, rd)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 1'b1, er)
    $display("test regs done");
  endtask

  // stale remote bias must not block the first start
  task automatic t_force_standby();
    start_up();
    env.remoteAbove <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    `CHK("pullDown", 1'b1, drive.remotePullDown)
    `CHK("forcedRun", standby_fault_sequencer_pkg::ST_RUN, seqState)
    wait_state(standby_fault_sequencer_pkg::ST_STANDBY, 40);
    `CHK("sbInhibit", 1'b1, drive.inhibit)
    `CHK("sbLowPower", 1'b1, drive.lowPower)
    env.remoteAbove <= 1'b0;
    env.remoteBelowExit <= 1'b1;
    env.aboveStart <= 1'b0;
    wait_state(standby_fault_sequencer_pkg::ST_DRAIN, 10);
    env.remoteBelowExit <= 1'b0;
    start_up();
    `CHK("noForce", 1'b0, drive.remotePullDown)
    $display("test standby done");
  endtask

  task automatic t_retry();
    env.aboveStart <= 1'b0;
    env.belowUv <= 1'b1;
    wait_state(standby_fault_sequencer_pkg::ST_RETRY, 5);
    `CHK("hold", 1'b1, drive.holdRegulate)
    `CHK("retryInhibit", 1'b1, drive.inhibit)
    repeat (10) @(posedge ref_clk);
    #1;
    `CHK("stillRetry", standby_fault_sequencer_pkg::ST_RETRY, seqState)
    env.belowUv <= 1'b0;
    wait_state(standby_fault_sequencer_pkg::ST_DRAIN, 30);
    `CHK("drain", 1'b1, drive.drainSwitch)
    start_up();
    `CHK("faultForce", 1'b1, drive.remotePullDown)
    $display("test retry done");
  endtask

  task automatic t_latch();
    env.slaveShutdown <= 1'b1;
    wait_state(standby_fault_sequencer_pkg::ST_LATCHED, 5);
    env.slaveShutdown <= 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    `CHK("latchHeld", standby_fault_sequencer_pkg::ST_LATCHED, seqState)
    `CHK("latchInhibit", 1'b1, drive.inhibit)
    env.aboveStart <= 1'b0;
    env.lineCapDischarge <= 1'b1;
    wait_state(standby_fault_sequencer_pkg::ST_DRAIN, 5);
    env.lineCapDischarge <= 1'b0;
    $display("test latch done");
  endtask

  // slave ready ends charging early, without the start level
  task automatic t_ready_hot();
    env.slaveReady <= 1'b1;
    env.drained <= 1'b1;
    wait_state(standby_fault_sequencer_pkg::ST_CHARGE, 10);
    env.drained <= 1'b0;
    wait_state(standby_fault_sequencer_pkg::ST_RUN, 20);
    `CHK("srcOff", 1'b0, drive.startSource)
    env.aboveStart <= 1'b1;
    env.thermalTrip <= 1'b1;
    wait_state(standby_fault_sequencer_pkg::ST_HOT, 3);
    `CHK("hotInhibit", 1'b1, drive.inhibit)
    env.thermalTrip <= 1'b0;
    env.aboveStart <= 1'b0;
    wait_state(standby_fault_sequencer_pkg::ST_DRAIN, 5);
    `CHK("hotDrain", 1'b1, drive.drainSwitch)
    env.slaveReady <= 1'b0;
    $display("test ready and thermal done");
  endtask

  // low-true variant: standby comes from a collapsed supply with remote low
  task automatic t_low_true();
    clkEn <= 1'b0;
    env.drained <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK("frozen", standby_fault_sequencer_pkg::ST_DRAIN, seqState)
    env.drained <= 1'b0;
    clkEn <= 1'b1;
    apb(1'b1, standby_fault_sequencer_pkg::CTRL_ADDR, 32'h00000003);
    start_up();
    `CHK("lowNoPull", 1'b0, drive.remotePullDown)
    env.belowUv <= 1'b1;
    wait_state(standby_fault_sequencer_pkg::ST_STANDBY, 5);
    `CHK("lowSbDrain", 1'b1, drive.drainSwitch)
    env.belowUv <= 1'b0;
    env.aboveStart <= 1'b0;
    env.remoteAbove <= 1'b1;
    wait_state(standby_fault_sequencer_pkg::ST_DRAIN, 5);
    env.remoteAbove <= 1'b0;
    apb(1'b1, standby_fault_sequencer_pkg::CTRL_ADDR, 32'h00000001);
    $display("test low-true done");
  endtask

  // line sag re-arms the force timer; a supply forced low cuts the retry
  task automatic t_sag_four();
    start_up();
    env.lineSag <= 1'b1;
    wait_state(standby_fault_sequencer_pkg::ST_DRAIN, 5);
    `CHK("sagInhibit", 1'b1, drive.inhibit)
    env.lineSag <= 1'b0;
    env.aboveStart <= 1'b0;
    start_up();
    `CHK("sagForce", 1'b1, drive.remotePullDown)
    env.aboveStart <= 1'b0;
    env.belowUv <= 1'b1;
    wait_state(standby_fault_sequencer_pkg::ST_RETRY, 5);
    env.belowFour <= 1'b1;
    wait_state(standby_fault_sequencer_pkg::ST_DRAIN, 3);
    `CHK("fourDrain", 1'b1, drive.drainSwitch)
    env.belowUv <= 1'b0;
    env.belowFour <= 1'b0;
    $display("test sag and forced supply done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1;
    t_regs();
    t_force_standby();
    t_retry();
    t_latch();
    t_ready_hot();
    t_low_true();
    t_sag_four();
    tally_and_finish();
  end

  // the whole run needs well under two thousand cycles
  initial begin
    #(25 * 20000);
    err_total++;
    tally_and_finish();
  end
endmodule
